// File: sadc_pkg.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package sadc_pkg;

  // register map, word offsets on the plain register port
  localparam int SADC_AW = 3;
  localparam int SADC_DW = 16;
  localparam logic [2:0] SADC_OFS_CTL2 = 3'h0;
  localparam logic [2:0] SADC_OFS_CTL3 = 3'h1;
  localparam logic [2:0] SADC_OFS_INSEL = 3'h2;
  localparam logic [2:0] SADC_OFS_PINCFG = 3'h3;
  localparam logic [2:0] SADC_OFS_SCAN = 3'h4;

  // control two fields
  localparam int SADC_REF_LSB = 13;
  localparam int SADC_SCAN_EN_BIT = 10;
  localparam int SADC_FILL_BIT = 7;
  localparam int SADC_RATE_LSB = 2;
  localparam int SADC_SPLIT_BIT = 1;
  localparam int SADC_ALT_BIT = 0;

  // control three fields
  localparam int SADC_CLKSRC_BIT = 15;
  localparam int SADC_SAMT_LSB = 8;
  localparam int SADC_DIV_LSB = 0;

  // input select fields
  localparam int SADC_NEGB_BIT = 15;
  localparam int SADC_POSB_LSB = 8;
  localparam int SADC_NEGA_BIT = 7;
  localparam int SADC_POSA_LSB = 0;

  // writable bits per register, the rest read as zero except the control two fill flag
  localparam logic [15:0] SADC_CTL2_WMASK = 16'he43f;
  localparam logic [15:0] SADC_CTL3_WMASK = 16'h9fff;
  localparam logic [15:0] SADC_INSEL_WMASK = 16'h9f9f;
  localparam logic [15:0] SADC_FULL_WMASK = 16'hffff;
  localparam logic [15:0] SADC_REG_RESET = 16'h0000;

  // trigger codes and divider ceiling
  localparam logic [2:0] SADC_TRIG_SW = 3'h0;
  localparam logic [2:0] SADC_TRIG_AUTO = 3'h7;
  localparam logic [7:0] SADC_DIV_MAX = 8'h3f;

  // analog pins and internal channels
  localparam int SADC_NPINS = 13;
  localparam int SADC_NCHAN = 16;

  typedef enum logic [1:0] {SADC_ST_IDLE, SADC_ST_SAMPLE, SADC_ST_CONV} sadc_state_t;

endpackage

// File: sadc_clkdiv.sv
`timescale 1ns/1ps
module sadc_clkdiv
  import sadc_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src_rc,
  input wire logic [DIV_W-1:0] div,
  input wire logic rc_clock,
  output logic tick
);

  if (DIV_W != 8) begin : g_chk
    $error("sadc_clkdiv supports only an 8-bit divider");
  end

  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic tick_d;
  logic [DIV_W-1:0] lim;

  //////////////////////////////////////////////////////////////////////////////
  // rc pin synchroniser, edge counts once stages two and three agree
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    lim = (div > SADC_DIV_MAX) ? SADC_DIV_MAX : div; // reserved codes clamp
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (src_rc) begin
      cnt_d = '0;
      tick_d = lvl_d & ~lvl_q;
    end else if (cnt_q >= lim) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      s1_q <= rc_clock;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      tick <= tick_d;
    end
  end

endmodule

// File: sadc_scan.sv
`timescale 1ns/1ps
module sadc_scan
  import sadc_pkg::*;
#(
  parameter int NCH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NCH-1:0] mask,
  input wire logic advance,
  output logic [$clog2(NCH)-1:0] chan
);

  if (NCH != SADC_NCHAN) begin : g_chk
    $error("sadc_scan channel count must match the scan register");
  end

  localparam int CW = $clog2(NCH);
  logic [CW-1:0] chan_d;
  logic found;

  //////////////////////////////////////////////////////////////////////////////
  // next enabled channel above the current one, else lowest enabled
  always_comb begin
    chan_d = chan;
    found = 1'b0;
    if (advance) begin
      for (int i = NCH - 1; i >= 0; i--) begin
        if (mask[i] && (i > int'(chan))) begin
          chan_d = CW'(i);
          found = 1'b1;
        end
      end
      if (!found) begin
        for (int i = NCH - 1; i >= 0; i--) begin
          if (mask[i]) begin
            chan_d = CW'(i);
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan <= '0;
    end else begin
      chan <= chan_d;
    end
  end

endmodule

// File: sadc_ctrl.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module sadc_ctrl
  import sadc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [SADC_AW-1:0] reg_addr,
  input wire logic [SADC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [SADC_DW-1:0] reg_rdata,
  input wire logic adc_on,
  input wire logic [2:0] trigger_source,
  input wire logic sample_bit,
  input wire logic ext_trigger,
  input wire logic rc_clock,
  input wire logic conv_done,
  output logic sampling,
  output logic start_conv,
  output logic result_write,
  output logic [3:0] result_addr,
  output logic conv_irq,
  output logic conv_tick,
  output logic conv_clock_rc,
  output logic ref_pos_ext,
  output logic ref_neg_ext,
  output logic [4:0] pos_channel,
  output logic neg_is_an1,
  output logic mux_second_active,
  output logic [SADC_NPINS-1:0] pin_digital,
  output logic [2:0] int_ref_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_s1_q, rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] ctl2_q, ctl2_d, ctl3_q, ctl3_d, insel_q, insel_d;
  logic [15:0] pincfg_q, pincfg_d, scan_q, scan_d, rdata_d, ctl2_rd;
  logic half_q, half_d;

  // field views
  logic [2:0] ref_cfg;
  logic scan_enable, buffer_split_mode, alternate_sample_mode, conv_clock_source;
  logic [3:0] interrupt_rate;
  logic [4:0] auto_sample_time, pos_select_first, pos_select_second;
  logic [7:0] conv_clock_divider;
  logic neg_select_first, neg_select_second;

  assign ref_cfg = ctl2_q[SADC_REF_LSB +: 3];
  assign scan_enable = ctl2_q[SADC_SCAN_EN_BIT];
  assign interrupt_rate = ctl2_q[SADC_RATE_LSB +: 4];
  assign buffer_split_mode = ctl2_q[SADC_SPLIT_BIT];
  assign alternate_sample_mode = ctl2_q[SADC_ALT_BIT];
  assign conv_clock_source = ctl3_q[SADC_CLKSRC_BIT];
  assign auto_sample_time = ctl3_q[SADC_SAMT_LSB +: 5];
  assign conv_clock_divider = ctl3_q[SADC_DIV_LSB +: 8];
  assign neg_select_second = insel_q[SADC_NEGB_BIT];
  assign pos_select_second = insel_q[SADC_POSB_LSB +: 5];
  assign neg_select_first = insel_q[SADC_NEGA_BIT];
  assign pos_select_first = insel_q[SADC_POSA_LSB +: 5];

  // writes through masks, reads one cycle later
  always_comb begin
    ctl2_d = ctl2_q;
    ctl3_d = ctl3_q;
    insel_d = insel_q;
    pincfg_d = pincfg_q;
    scan_d = scan_q;
    ctl2_rd = ctl2_q;
    ctl2_rd[SADC_FILL_BIT] = half_q;
    rdata_d = '0;
    if (reg_wr) begin
      if (reg_addr == SADC_OFS_CTL2) begin
        ctl2_d = reg_wdata & SADC_CTL2_WMASK; // fill flag not writable
      end else if (reg_addr == SADC_OFS_CTL3) begin
        ctl3_d = reg_wdata & SADC_CTL3_WMASK;
      end else if (reg_addr == SADC_OFS_INSEL) begin
        insel_d = reg_wdata & SADC_INSEL_WMASK;
      end else if (reg_addr == SADC_OFS_PINCFG) begin
        pincfg_d = reg_wdata & SADC_FULL_WMASK;
      end else if (reg_addr == SADC_OFS_SCAN) begin
        scan_d = reg_wdata & SADC_FULL_WMASK;
      end
    end
    if (reg_rd) begin
      if (reg_addr == SADC_OFS_CTL2) begin
        rdata_d = ctl2_rd;
      end else if (reg_addr == SADC_OFS_CTL3) begin
        rdata_d = ctl3_q;
      end else if (reg_addr == SADC_OFS_INSEL) begin
        rdata_d = insel_q;
      end else if (reg_addr == SADC_OFS_PINCFG) begin
        rdata_d = pincfg_q;
      end else if (reg_addr == SADC_OFS_SCAN) begin
        rdata_d = scan_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl2_q <= SADC_REG_RESET;
      ctl3_q <= SADC_REG_RESET;
      insel_q <= SADC_REG_RESET;
      pincfg_q <= SADC_REG_RESET;
      scan_q <= SADC_REG_RESET;
      reg_rdata <= '0;
    end else begin
      ctl2_q <= ctl2_d;
      ctl3_q <= ctl3_d;
      insel_q <= insel_d;
      pincfg_q <= pincfg_d;
      scan_q <= scan_d;
      reg_rdata <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion clock and scan position
  logic scan_adv;
  logic [3:0] scan_chan;

  sadc_clkdiv #(
    .DIV_W(8)
  ) u_clkdiv (
    .clk(clk),
    .rst_n(rst_n),
    .src_rc(conv_clock_source),
    .div(conv_clock_divider),
    .rc_clock(rc_clock),
    .tick(conv_tick)
  );

  sadc_scan #(
    .NCH(SADC_NCHAN)
  ) u_scan (
    .clk(clk),
    .rst_n(rst_n),
    .mask(scan_q),
    .advance(scan_adv),
    .chan(scan_chan)
  );

  //////////////////////////////////////////////////////////////////////////////
  // external trigger pin filter, three stages
  logic tr1_q, tr2_q, tr3_q, trl_q, trl_d, trig_edge;

  always_comb begin
    trl_d = (tr2_q == tr3_q) ? tr3_q : trl_q;
    trig_edge = trl_d & ~trl_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tr1_q <= 1'b0;
      tr2_q <= 1'b0;
      tr3_q <= 1'b0;
      trl_q <= 1'b0;
    end else begin
      tr1_q <= ext_trigger;
      tr2_q <= tr1_q;
      tr3_q <= tr2_q;
      trl_q <= trl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sample/convert sequencer
  sadc_state_t state_q, state_d;
  logic [4:0] sample_bit_cnt_q, sample_bit_cnt_d;
  logic [3:0] seq_cnt_q, seq_cnt_d, widx_q, widx_d, waddr_d;
  logic alt_q, alt_d, end_sample_bit, start_d, wr_d, irq_d;

  always_comb begin
    state_d = state_q;
    sample_bit_cnt_d = sample_bit_cnt_q;
    seq_cnt_d = seq_cnt_q;
    widx_d = widx_q;
    half_d = buffer_split_mode ? half_q : 1'b0;
    alt_d = alternate_sample_mode ? alt_q : 1'b0;
    start_d = 1'b0;
    wr_d = 1'b0;
    irq_d = 1'b0;
    scan_adv = 1'b0;
    end_sample_bit = 1'b0;
    // split: half selects upper address bit, else linear index
    waddr_d = buffer_split_mode ? {half_q, widx_q[2:0]} : widx_q;
    if (trigger_source == SADC_TRIG_SW) begin
      end_sample_bit = ~sample_bit;
    end else if (trigger_source == SADC_TRIG_AUTO) begin
      end_sample_bit = (sample_bit_cnt_q >= auto_sample_time);
    end else begin
      end_sample_bit = trig_edge;
    end
    if (!adc_on) begin
      state_d = SADC_ST_IDLE;
      seq_cnt_d = '0;
      widx_d = '0;
      half_d = 1'b0;
      alt_d = 1'b0;
    end else begin
      case (state_q)
        SADC_ST_IDLE: begin
          sample_bit_cnt_d = '0;
          if (sample_bit) begin
            state_d = SADC_ST_SAMPLE;
          end
        end
        SADC_ST_SAMPLE: begin
          if (end_sample_bit) begin
            state_d = SADC_ST_CONV;
            start_d = 1'b1;
          end else if (conv_tick && sample_bit_cnt_q != 5'h1f) begin
            sample_bit_cnt_d = sample_bit_cnt_q + 5'h01;
          end
        end
        default: begin
          if (conv_done) begin
            state_d = SADC_ST_IDLE;
            wr_d = 1'b1;
            alt_d = alternate_sample_mode & ~alt_q;
            scan_adv = scan_enable & ~alt_q;
            if (seq_cnt_q == interrupt_rate) begin
              irq_d = 1'b1;
              seq_cnt_d = '0;
              widx_d = '0;
              alt_d = 1'b0;
              half_d = buffer_split_mode & ~half_q;
            end else begin
              seq_cnt_d = seq_cnt_q + 4'h1;
              widx_d = widx_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SADC_ST_IDLE;
      sample_bit_cnt_q <= '0;
      seq_cnt_q <= '0;
      widx_q <= '0;
      half_q <= 1'b0;
      alt_q <= 1'b0;
      start_conv <= 1'b0;
      result_write <= 1'b0;
      result_addr <= '0;
      conv_irq <= 1'b0;
    end else begin
      state_q <= state_d;
      sample_bit_cnt_q <= sample_bit_cnt_d;
      seq_cnt_q <= seq_cnt_d;
      widx_q <= widx_d;
      half_q <= half_d;
      alt_q <= alt_d;
      start_conv <= start_d;
      result_write <= wr_d;
      result_addr <= wr_d ? waddr_d : result_addr;
      conv_irq <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog front-end steering, registered
  logic ref_pos_d, ref_neg_d, neg_d, smp_d;
  logic [4:0] pos_d;

  always_comb begin
    ref_pos_d = ~ref_cfg[2] & ref_cfg[0];
    ref_neg_d = ~ref_cfg[2] & ref_cfg[1];
    // same code table for both settings: 0-12 pins, 13-15 internal, 31 timing
    if (alt_q) begin
      pos_d = pos_select_second;
      neg_d = neg_select_second;
    end else begin
      pos_d = scan_enable ? {1'b0, scan_chan} : pos_select_first;
      neg_d = neg_select_first;
    end
    smp_d = (state_q == SADC_ST_SAMPLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_pos_ext <= 1'b0;
      ref_neg_ext <= 1'b0;
      pos_channel <= '0;
      neg_is_an1 <= 1'b0;
      mux_second_active <= 1'b0;
      sampling <= 1'b0;
      conv_clock_rc <= 1'b0;
      pin_digital <= '0;
      int_ref_enable <= '0;
    end else begin
      ref_pos_ext <= ref_pos_d;
      ref_neg_ext <= ref_neg_d;
      pos_channel <= pos_d;
      neg_is_an1 <= neg_d;
      mux_second_active <= alt_q;
      sampling <= smp_d;
      conv_clock_rc <= conv_clock_source;
      pin_digital <= pincfg_q[SADC_NPINS-1:0];
      int_ref_enable <= ~pincfg_q[15:13];
    end
  end

endmodule

// File: sadc_ctrl_checker.sv
`timescale 1ns/1ps
module sadc_ctrl_checker
  import sadc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [SADC_AW-1:0] reg_addr,
  input wire logic [SADC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [SADC_DW-1:0] reg_rdata,
  input wire logic conv_done,
  input wire logic sampling,
  input wire logic start_conv,
  input wire logic result_write,
  input wire logic conv_irq,
  input wire logic conv_clock_rc,
  input wire logic ref_pos_ext,
  input wire logic ref_neg_ext,
  input wire logic [SADC_NPINS-1:0] pin_digital,
  input wire logic [2:0] int_ref_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // register fields reach the outputs within three quiet cycles
  ref_sel_a: assert property (
    reg_wr && reg_addr == SADC_OFS_CTL2 ##1 !reg_wr [*3] |-> {ref_pos_ext, ref_neg_ext} ==
    ($past(reg_wdata[15], 3) ? 2'h0 : {$past(reg_wdata[13], 3), $past(reg_wdata[14], 3)}))
    else $error("reference select wrong");
  clk_src_a: assert property (
    reg_wr && reg_addr == SADC_OFS_CTL3 ##1 !reg_wr [*3] |->
    conv_clock_rc == $past(reg_wdata[SADC_CLKSRC_BIT], 3)) else $error("clock source wrong");
  pin_mode_a: assert property (
    reg_wr && reg_addr == SADC_OFS_PINCFG ##1 !reg_wr [*3] |->
    pin_digital == $past(reg_wdata[12:0], 3)) else $error("pin mode wrong");
  int_ref_a: assert property (
    reg_wr && reg_addr == SADC_OFS_PINCFG ##1 !reg_wr [*3] |->
    int_ref_enable == ~$past(reg_wdata[15:13], 3)) else $error("internal channel enable wrong");
  ////////////////////////////////////////////////////////////////
  // sequencer pulses
  irq_write_a: assert property (conv_irq |-> result_write) else $error("lone interrupt");
  write_done_a: assert property (result_write |-> $past(conv_done))
    else $error("write without done");
  conv_start_a: assert property (start_conv |=> !start_conv && !sampling)
    else $error("sampling kept after start");
  ////////////////////////////////////////////////////////////////
  // read side
  unmapped_a: assert property (reg_rd && reg_addr > SADC_OFS_SCAN |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  reserved_a: assert property (
    reg_rd && reg_addr == SADC_OFS_CTL2 |=> (reg_rdata & ~(SADC_CTL2_WMASK | 16'h0080)) == 16'h0)
    else $error("reserved bits set");
endmodule

bind sadc_ctrl sadc_ctrl_checker sadc_ctrl_checker_inst (.clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .conv_done, .sampling, .start_conv, .result_write, .conv_irq,
  .conv_clock_rc, .ref_pos_ext, .ref_neg_ext, .pin_digital, .int_ref_enable);

// File: sadc_ctrl_bench.sv
`timescale 1ns/1ps
module sadc_ctrl_bench
  import sadc_pkg::*;
;
  logic clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, adc_on = 1'h0;
  logic sample_bit = 1'h0, ext_trigger = 1'h0, rc_clock = 1'h0, conv_done = 1'h0, rd_d = 1'h0;
  logic [2:0] reg_addr = 3'h0, trigger_source = 3'h0, int_ref_enable;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, insel = 16'h8a03, scanm = 16'h4021;
  logic sampling, start_conv, result_write, conv_irq, conv_tick, conv_clock_rc;
  logic ref_pos_ext, ref_neg_ext, neg_is_an1, mux_second_active;
  logic [3:0] result_addr;
  logic [4:0] pos_channel, sc = 5'h0;
  logic [12:0] pin_digital;
  logic [15:0] rd_q[$];
  logic [4:0] wr_q[$];
  int failures = 0, n_compared = 0, cycles = 0, ticks = 0;

  always #4 clk = ~clk;

  sadc_ctrl sadc_ctrl_inst (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .adc_on, .trigger_source, .sample_bit, .ext_trigger, .rc_clock, .conv_done, .sampling,
    .start_conv, .result_write, .result_addr, .conv_irq, .conv_tick, .conv_clock_rc, .ref_pos_ext,
    .ref_neg_ext, .pos_channel, .neg_is_an1, .mux_second_active, .pin_digital, .int_ref_enable);

  ////////////////////////////////////////////////////////////////
  // compare, verdict and bus access
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic access(input logic w, input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    access(1'h0, a, 16'h0);
  endtask

  // one configuration, cnt sample/convert sequences
  task automatic run(input logic [15:0] c2, input logic [2:0] trig, input int cnt);
    int k;
    int j;
    int n;
    logic half;
    logic sec;
    logic [6:0] e;
    adc_on <= 1'h0;
    access(1'h1, SADC_OFS_CTL2, c2);
    adc_on <= 1'h1;
    trigger_source <= trig;
    half = 1'h0;
    for (k = 0; k < cnt; k++) begin
      j = k % (c2[5:2] + 1);
      sec = c2[0] & j[0];
      e = {sec, sec ? insel[15] : insel[7], sec ? insel[12:8] : (c2[10] ? sc : insel[4:0])};
      sample_bit <= 1'h1;
      for (n = 0; n < 300 && !sampling; n++) @(posedge clk);
      check({9'h0, mux_second_active, neg_is_an1, pos_channel}, {9'h0, e});
      sample_bit <= 1'h0;
      ext_trigger <= 1'h1;
      for (n = 0; n < 300 && !start_conv; n++) @(posedge clk);
      // auto mode: two sample periods of two cycles each, give or take the tick phase
      if (trig == 3'h7) check(16'((n + 1) / 2), 16'h2);
      ext_trigger <= 1'h0;
      conv_done <= 1'h1;
      wr_q.push_back({j == c2[5:2], c2[1] ? {half, j[2:0]} : j[3:0]});
      @(posedge clk);
      conv_done <= 1'h0;
      if (c2[10] && !sec) begin
        do sc = (sc + 5'h1) & 5'hf; while (!scanm[sc[3:0]]);
      end
      if (j == c2[5:2]) half = ~half;
      if (j == c2[5:2] && c2[1]) rd(SADC_OFS_CTL2, c2 | {8'h0, half, 7'h0});
      repeat (3) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // output watcher, tick counter and timeout
  always @(posedge clk) begin
    rd_d <= reg_rd;
    cycles <= cycles + 1;
    if (conv_tick) ticks <= ticks + 1;
    if (rd_d) check(reg_rdata, rd_q.pop_front());
    if (result_write) check({11'h0, conv_irq, result_addr}, {11'h0, wr_q.pop_front()});
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  // main sequence
  initial begin
    int a;
    int n;
    int t0;
    logic [15:0] d;
    logic [15:0] wm [8];
    logic [7:0] dv [3];
    wm = '{SADC_CTL2_WMASK, 16'h9f3f, 16'h8f8f, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0};
    dv = '{8'h0, 8'h5, 8'h3f};
    void'($urandom(32'hc7b1));
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    adc_on <= 1'h1;
    repeat (4) @(posedge clk);
    check({pin_digital, int_ref_enable}, 16'h0007);
    for (a = 0; a < 8; a++) rd(a[2:0], 16'h0);
    for (a = 0; a < 8; a++) begin
      d = 16'($urandom());
      access(1'h1, a[2:0], a < 5 ? d & wm[a] : d);
      rd(a[2:0], d & wm[a]);
      if (a == 3) check({~int_ref_enable, pin_digital}, d);
    end
    for (a = 0; a < 8; a++) begin
      access(1'h1, SADC_OFS_CTL2, 16'(a) << 13);
      @(posedge clk);
      check({14'h0, ref_pos_ext, ref_neg_ext}, a[2] ? 16'h0 : {14'h0, a[0], a[1]});
    end
    for (a = 0; a < 3; a++) begin
      access(1'h1, SADC_OFS_CTL3, {8'h0, dv[a]});
      repeat (2) begin
        for (n = 0; n < 200 && !conv_tick; n++) @(posedge clk);
        @(posedge clk);
      end
      for (n = 1; n < 200 && !conv_tick; n++) @(posedge clk);
      check(16'(n), 16'(dv[a]) + 16'h1);
    end
    access(1'h1, SADC_OFS_CTL3, 16'h8000);
    repeat (4) @(posedge clk);
    t0 = ticks;
    repeat (4) begin
      rc_clock <= 1'h1;
      repeat (5) @(posedge clk);
      rc_clock <= 1'h0;
      repeat (5) @(posedge clk);
    end
    check({15'h0, conv_clock_rc}, 16'h1);
    check(16'(ticks - t0), 16'h4);
    access(1'h1, SADC_OFS_CTL3, 16'h0201);
    access(1'h1, SADC_OFS_INSEL, insel);
    access(1'h1, SADC_OFS_SCAN, scanm);
    run(16'h040c, 3'h0, 5);
    run(16'h000f, 3'h7, 8);
    run(16'h0000, 3'h1, 2);
    run(16'h003c, 3'h0, 17);
    check(16'(wr_q.size()), 16'h0);
    stop_test();
  end
endmodule
